// file: verilog/fsq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Silicon ID command 0xab, smaller variants only
// R2: ID commands ignored during self-timed cycle
// R3: Three dummies, then 8-bit ID, falling edges
// R4: ID repeats while select stays low
// R5: Device ID command 0x9f, largest variant only
// R6: Two dummies, then wide ID out
// R7: Page program 0x02 needs write enable latch
// R8: Host sends command, address, data in one frame
// R9: Data past page end wraps inside page
// R10: Only last 256 bytes kept, others untouched
// R11: Host repeats enable and frame per page
// R12: Select rise off byte boundary discards command
// R13: Latch cleared before program completes
// R14: Select rise starts program, busy flag set
// R15: Bulk erase 0xc7 sets all bits, needs latch
// R16: Bulk erase frame is one byte
// R17: Erase holds busy flag, clears latch
// R18: Sector erase 0xd8 plus address erases sector
// R19: Select rise starts sector erase immediately
// R20: Top address bit ignored
// R21: Host sends image bytes lsb first
// R22: Active while selected or cycle running
// R23: Host restarts configuration on error
// R24: Outside logic pulses reconfig request low
// R25: Sample on rising, drive on falling edges
// R26: Busy flag is status bit zero
// R27: Protected sectors never programmed or erased
// R28: Commands without latch set are ignored
module fsq_sequencer
  import fsq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
  parameter int unsigned SECT_CYCLES_P = SECT_CYCLES,
  parameter int unsigned BULK_CYCLES_P = BULK_CYCLES,
  parameter bit          LARGEST_P     = 1'b0
) (
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  // Serial link pins
  input  wire logic                serial_clock_i,
  input  wire logic                select_n_i,
  input  wire logic                serial_cmd_in_i,
  output logic                     serial_data_o,
  output logic                     serial_data_oe_o,
  // Status and protection
  input  wire logic [2:0]          protect_bits_i,
  output logic [7:0]               status_o,
  output logic                     active_o,
  // Array core port
  output logic                     core_start_o,
  output fsq_core_req_s            core_req_o,
  input  wire logic [PAGE_W-1:0]   core_rd_idx_i,
  output logic [7:0]               core_rd_byte_o,
  output logic                     core_rd_keep_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: shifter on rising serial clock, cleared by select high

  logic [2:0]        bit_cnt;
  logic [2:0]        byte_cnt;
  logic [6:0]        shift;
  logic [7:0]        cmd;
  logic [23:0]       addr;
  logic [PAGE_W-1:0] data_idx;
  logic [7:0]        page_data [0:255];
  logic [255:0]      page_keep;
  logic              link_busy;
  logic [7:0]        next_byte;
  logic              byte_done;
  logic [PAGE_W-1:0] wr_idx;

  assign next_byte = {shift, serial_cmd_in_i};
  assign byte_done = (bit_cnt == 3'h7);
  // R9: write index wraps within the page
  assign wr_idx    = addr[PAGE_W-1:0] + data_idx;

  // Busy flag into the link clock for ID gating
  fsq_sync #(.W(1)) u_busy_sync (
    .clk_i   (serial_clock_i),
    .async_i (status_o[STAT_WIP_BIT]),
    .sync_o  (link_busy)
  );

  // R25: bit and byte counting on rising edges
  always_ff @(posedge serial_clock_i or posedge select_n_i) begin
    if (select_n_i) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shift    <= 7'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= next_byte[6:0];
      if (byte_done && byte_cnt != LEN_BYTE_MAX) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // Command and address capture, msb first
  always_ff @(posedge serial_clock_i) begin
    if (!select_n_i && byte_done) begin
      if (byte_cnt == 3'h0) begin
        cmd <= next_byte;
      end else if (byte_cnt < LEN_PROG_HEADER) begin
        addr <= {addr[15:0], next_byte};
      end
    end
  end

  // Data index counts data bytes of the current frame
  always_ff @(posedge serial_clock_i or posedge select_n_i) begin
    if (select_n_i) begin
      data_idx <= 8'h00;
    end else if (byte_done && byte_cnt >= LEN_PROG_HEADER && cmd == CMD_PAGE_PROG) begin
      data_idx <= data_idx + 8'h01;
    end
  end

  // R10: later bytes overwrite earlier, untouched bytes keep mask clear
  // Buffer is frozen while a cycle runs so the core reads stable data
  always_ff @(posedge serial_clock_i) begin
    if (!select_n_i && byte_done && !link_busy) begin
      if (byte_cnt == 3'h0 && next_byte == CMD_PAGE_PROG) begin
        page_keep <= '0;
      end else if (byte_cnt >= LEN_PROG_HEADER && cmd == CMD_PAGE_PROG) begin
        page_data[wr_idx] <= next_byte;
        page_keep[wr_idx] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Identification output on falling serial clock

  logic        id_sid_ok;
  logic        id_did_ok;
  logic [3:0]  out_ptr;
  logic [3:0]  top_bit;
  logic [15:0] id_word;

  // R1: silicon ID only on smaller variants
  // R5: device ID only on the largest variant
  // R2: both ignored while a cycle runs
  assign id_sid_ok = !LARGEST_P && !link_busy && cmd == CMD_SILICON_ID &&
                     byte_cnt >= LEN_SID_HEADER;
  assign id_did_ok = LARGEST_P && !link_busy && cmd == CMD_DEVICE_ID &&
                     byte_cnt >= LEN_DID_HEADER;
  assign top_bit   = id_did_ok ? DID_TOP_BIT : SID_TOP_BIT;
  assign id_word   = id_did_ok ? DEVICE_ID : {8'h00, SILICON_ID};

  // R3: ID bits change on falling edges after the dummies
  // R6: wide ID when the device ID command is used
  // R4: pointer wraps so the ID repeats until select rises
  always_ff @(negedge serial_clock_i or posedge select_n_i) begin
    if (select_n_i) begin
      out_ptr          <= 4'h0;
      serial_data_o    <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end else if (id_sid_ok || id_did_ok) begin
      serial_data_o    <= id_word[serial_data_oe_o ? out_ptr : top_bit];
      serial_data_oe_o <= 1'b1;
      if (!serial_data_oe_o) begin
        out_ptr <= (top_bit == 4'h0) ? top_bit : top_bit - 4'h1;
      end else begin
        out_ptr <= (out_ptr == 4'h0) ? top_bit : out_ptr - 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame summary frozen on select rise, announced by the synced select rise

  fsq_frame_s frame;

  // Link clock is stopped here, so shifter state is stable
  // Held until the next select rise, long after the system side has read it
  always_ff @(posedge select_n_i) begin
    frame.cmd     <= cmd;
    frame.addr    <= addr;
    frame.bytes   <= byte_cnt;
    frame.aligned <= (bit_cnt == 3'h0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: decode finished frames, run self-timed cycles

  logic        sel_n_sync;
  logic        sel_n_seen;
  logic        frame_evt;
  fsq_state_e  state;
  logic        wel;
  logic        timer_start;
  logic [31:0] timer_cycles;
  logic        timer_busy;
  logic        timer_done;
  logic        len_ok;
  logic        go_prog;
  logic        go_sect;
  logic        go_bulk;
  logic [SECTOR_W-1:0] prot_first;
  logic        sect_protected;

  // Synced select rise marks a finished frame; the summary is stable by then
  // since select itself froze it, so no toggle without reset is needed
  fsq_sync #(.W(1)) u_sys_sync (
    .clk_i   (sys_clk_i),
    .async_i (select_n_i),
    .sync_o  (sel_n_sync)
  );
  assign frame_evt = sel_n_sync && !sel_n_seen;

  // Rise detect; resets to the deselected level so no false edge follows
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sel_n_seen <= 1'b1;
    end else begin
      sel_n_seen <= sel_n_sync;
    end
  end

  // R27: upper 2^n sectors protected, all at code 7
  always_comb begin
    if (protect_bits_i == 3'h0) begin
      prot_first = SECTOR_LAST;
    end else if (protect_bits_i == 3'h7) begin
      prot_first = '0;
    end else begin
      prot_first = SECTOR_LAST + 7'h1 - 7'(7'h1 << protect_bits_i);
    end
  end
  // R20: bit 23 never reaches the sector compare
  assign sect_protected = (protect_bits_i != 3'h0) &&
                          (frame.addr[SECTOR_LSB +: SECTOR_W] >= prot_first);

  // R12: select must rise on a byte boundary
  assign len_ok  = frame.aligned && frame_evt && state == ST_IDLE;
  // R28: nothing starts without the latch set
  // R7: page program needs latch and at least one data byte
  assign go_prog = len_ok && wel && frame.cmd == CMD_PAGE_PROG &&
                   frame.bytes >= LEN_PROG_MIN && !sect_protected;
  // R18: any address inside the sector selects it
  assign go_sect = len_ok && wel && frame.cmd == CMD_SECTOR_ERASE &&
                   frame.bytes == LEN_SECTOR_ERASE && !sect_protected;
  // R15: bulk erase only when no sector is protected
  // R16: bulk frame is the command byte alone
  assign go_bulk = len_ok && wel && frame.cmd == CMD_BULK_ERASE &&
                   frame.bytes == LEN_ONE_BYTE && protect_bits_i == 3'h0;

  // Cycle length per operation
  always_comb begin
    timer_start  = go_prog || go_sect || go_bulk;
    timer_cycles = PROG_CYCLES_P;
    if (go_sect) begin
      timer_cycles = SECT_CYCLES_P;
    end else if (go_bulk) begin
      timer_cycles = BULK_CYCLES_P;
    end
  end

  fsq_timer u_timer (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (timer_start),
    .cycles_i  (timer_cycles),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  // R14: cycle starts on select rise, busy until timer ends
  // R19: sector erase also starts without delay
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (timer_start) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (timer_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // R13: latch cleared as the program cycle starts
  // R17: same for both erases, well before completion
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wel <= RST_WEL;
    end else if (timer_start) begin
      wel <= 1'b0;
    end else if (len_ok && frame.bytes == LEN_ONE_BYTE) begin
      if (frame.cmd == CMD_WRITE_EN) begin
        wel <= 1'b1;
      end else if (frame.cmd == CMD_WRITE_DIS) begin
        wel <= 1'b0;
      end
    end
  end

  // Core request, address held through the whole cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      core_start_o    <= 1'b0;
      core_req_o.op   <= OP_PROG;
      core_req_o.addr <= '0;
    end else begin
      core_start_o <= timer_start;
      if (timer_start) begin
        core_req_o.op   <= go_sect ? OP_SECT : (go_bulk ? OP_BULK : OP_PROG);
        // R20: top address bit dropped
        core_req_o.addr <= frame.addr[ADDR_W-1:0];
      end
    end
  end

  // Page buffer read for the core; stable while busy
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      core_rd_byte_o <= 8'hff;
      core_rd_keep_o <= 1'b0;
    end else begin
      core_rd_byte_o <= page_data[core_rd_idx_i];
      core_rd_keep_o <= page_keep[core_rd_idx_i];
    end
  end

  // R26: busy flag in bit zero, latch in bit one
  always_comb begin
    status_o               = 8'h00;
    status_o[STAT_WIP_BIT] = (state == ST_BUSY) || timer_busy;
    status_o[STAT_WEL_BIT] = wel;
  end

  // R22: standby only once deselected and idle
  assign active_o = !sel_n_sync || status_o[STAT_WIP_BIT];

endmodule // fsq_sequencer

`default_nettype wire

// file: pkg/fsq_pkg.sv
package fsq_pkg;

  // Local clock and derived rates
  localparam int unsigned SYS_CLK_HZ = 25_000_000;

  // Command bytes, most significant bit first on the link
  localparam logic [7:0] CMD_SILICON_ID   = 8'hab;
  localparam logic [7:0] CMD_DEVICE_ID    = 8'h9f;
  localparam logic [7:0] CMD_PAGE_PROG    = 8'h02;
  localparam logic [7:0] CMD_BULK_ERASE   = 8'hc7;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] CMD_WRITE_EN     = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;

  // Frame lengths in whole bytes (saturating count)
  localparam logic [2:0] LEN_ONE_BYTE     = 3'h1;
  localparam logic [2:0] LEN_SECTOR_ERASE = 3'h4;
  localparam logic [2:0] LEN_PROG_HEADER  = 3'h4;
  localparam logic [2:0] LEN_PROG_MIN     = 3'h5;
  localparam logic [2:0] LEN_BYTE_MAX     = 3'h7;
  localparam logic [2:0] LEN_SID_HEADER   = 3'h4;  // Command plus three dummies
  localparam logic [2:0] LEN_DID_HEADER   = 3'h3;  // Command plus two dummies

  // Array geometry: 64-megabit part, top address bit ignored
  localparam int ADDR_W     = 23;
  localparam int PAGE_W     = 8;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W   = 7;
  localparam logic [SECTOR_W-1:0] SECTOR_LAST = 7'h7f;

  // Status bit positions and reset values
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic RST_WEL = 1'b0;

  // Identification widths and codes (arbitrary values)
  localparam int          SID_W       = 8;
  localparam int          DID_W       = 16;
  localparam logic [7:0]  SILICON_ID  = 8'h5a;
  localparam logic [15:0] DEVICE_ID   = 16'h3c7e;
  localparam logic [3:0]  SID_TOP_BIT = 4'h7;
  localparam logic [3:0]  DID_TOP_BIT = 4'hf;

  // Longest self-timed cycle times, rounded down to whole clocks
  localparam int unsigned PROG_TIME_US       = 5000;
  localparam int unsigned SECT_ERASE_TIME_MS = 3000;
  localparam int unsigned BULK_ERASE_TIME_S  = 160;
  localparam int unsigned PROG_CYCLES =
    int'(longint'(PROG_TIME_US) * longint'(SYS_CLK_HZ) / 64'd1_000_000);
  localparam int unsigned SECT_CYCLES =
    int'(longint'(SECT_ERASE_TIME_MS) * longint'(SYS_CLK_HZ) / 64'd1_000);
  localparam int unsigned BULK_CYCLES =
    int'(longint'(BULK_ERASE_TIME_S) * longint'(SYS_CLK_HZ));

  typedef enum logic [1:0] {
    OP_PROG = 2'b00,
    OP_SECT = 2'b01,
    OP_BULK = 2'b10
  } fsq_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } fsq_state_e;

  // Summary of one select-low frame, frozen at select rise
  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [2:0]  bytes;
    logic        aligned;
  } fsq_frame_s;

  // Request to the array core
  typedef struct packed {
    fsq_op_e           op;
    logic [ADDR_W-1:0] addr;
  } fsq_core_req_s;

endpackage

// file: verilog/fsq_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-flop level synchroniser; only stage two is read outside
module fsq_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  // First stage feeds the second and nothing else
  always_ff @(posedge clk_i) begin
    stage1 <= async_i;
    sync_o <= stage1;
  end

endmodule // fsq_sync

`default_nettype wire

// file: verilog/fsq_timer.sv
`timescale 1ns/100ps
`default_nettype none

// Self-timed cycle counter, one pulse on completion
module fsq_timer (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [31:0] cycles_i,
  output logic             busy_o,
  output logic             done_o
);

  logic [31:0] remain;

  // Load on start, count down, flag the last cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      remain <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      remain <= cycles_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o && remain <= 32'h1) begin
      remain <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b1;
    end else begin
      remain <= busy_o ? remain - 32'h1 : remain;
      done_o <= 1'b0;
    end
  end

endmodule // fsq_timer

`default_nettype wire

// file: verif/fsq_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none

// Port checks on the sequencer, system clock domain only
module fsq_sequencer_chk
  import fsq_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          select_n_i,
  input  wire logic          serial_data_oe_o,
  input  wire logic [2:0]    protect_bits_i,
  input  wire logic [7:0]    status_o,
  input  wire logic          active_o,
  input  wire logic          core_start_o,
  input  wire fsq_core_req_s core_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // Launch step: busy raised and latch dropped with the start pulse
  sequence s_launch;
    core_start_o && status_o[0] && !status_o[1];
  endsequence
  // Shortest shortened cycle is still longer than eight clocks
  sequence s_busy_run;
    status_o[0] [*8];
  endsequence

  a_start_launch: assert property (core_start_o |-> s_launch)
    else $error("start without busy or with latch set");
  a_busy_holds: assert property (s_launch |=> s_busy_run)
    else $error("busy flag dropped early");
  a_start_single: assert property (core_start_o |=> !core_start_o)
    else $error("start pulse too long");
  a_busy_from_start: assert property ($rose(status_o[0]) |-> core_start_o)
    else $error("busy rose without start");
  a_start_deselect: assert property (core_start_o |-> select_n_i && $past(select_n_i))
    else $error("start while selected");
  a_no_start_busy: assert property (status_o[0] && $past(status_o[0]) |-> !core_start_o)
    else $error("start during running cycle");
  a_status_spare: assert property (status_o[7:2] == 6'h00)
    else $error("spare status bits set");
  a_active_busy: assert property (status_o[0] |-> active_o)
    else $error("standby during cycle");
  a_bulk_protect: assert property (core_start_o && core_req_o.op == OP_BULK
                                   |-> protect_bits_i == 3'h0)
    else $error("bulk erase with protection");
  a_req_held: assert property (!$stable(core_req_o) |-> core_start_o)
    else $error("request changed without start");
  a_id_quiet_busy: assert property (serial_data_oe_o |-> !status_o[0])
    else $error("id driven during cycle");
endmodule // fsq_sequencer_chk

bind fsq_sequencer fsq_sequencer_chk u_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .select_n_i(select_n_i),
  .serial_data_oe_o(serial_data_oe_o), .protect_bits_i(protect_bits_i),
  .status_o(status_o), .active_o(active_o), .core_start_o(core_start_o),
  .core_req_o(core_req_o));

`default_nettype wire

// file: verif/fsq_host.sv
`timescale 1ns/100ps
`default_nettype none

// Host end of the link; its clock idles low outside frames
module fsq_host (
  input  wire logic data_i,
  input  wire logic oe_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // bit set in low phase, read back at the rise
  task automatic bit_io(input logic b, inout logic [15:0] rd, inout logic oe);
    mosi_o = b;
    #32 sclk_o = 1'b1;
    rd = {rd[14:0], data_i};
    oe |= oe_i;
    #32 sclk_o = 1'b0;
  endtask

  // error restart: select pulsed low with no clock and no command
  task automatic restart();
    sel_n_o = 1'b0;
    #100 sel_n_o = 1'b1;
    #200;
  endtask

  // whole frame msb first; image bytes arrive pre-reversed
  task automatic frame(input logic [7:0] b[$], input int nrd,
                       output logic [15:0] rd, output logic oe);
    rd = 16'h0000;
    oe = 1'b0;
    sel_n_o = 1'b0;
    #20;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        bit_io(b[i][k], rd, oe);
    // trailing bits toggle, also used to break a byte boundary
    for (int k = 0; k < nrd; k++)
      bit_io(k[0], rd, oe);
    #20 sel_n_o = 1'b1;
    // Released line must not keep looking like data
    mosi_o = ~mosi_o;
    #200;
  endtask
endmodule // fsq_host

`default_nettype wire

// file: verif/fsq_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Bench: host model on the link, page buffer read back directly
module fsq_sequencer_tb_top;
  import fsq_pkg::*;
  localparam int LEN[3] = '{20, 30, 90};
  logic          sys_clk, resetn, sclk, sel_n, mosi, sdo, sdo_oe, sdo2, sdo_oe2;
  logic          active, start, keep, oe_seen;
  logic [2:0]    prot;
  logic [7:0]    status, rd_idx, rd_byte;
  logic [15:0]   rd;
  logic [7:0]    fr[$];
  fsq_core_req_s req;
  fsq_core_req_s exp_q[$];
  int            err_total, check_count, cyc;

  // Bulk cycle long enough to lay a whole ID frame inside it
  fsq_sequencer #(.PROG_CYCLES_P(20), .SECT_CYCLES_P(30), .BULK_CYCLES_P(90),
    .LARGEST_P(1'b0)) uut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .serial_clock_i(sclk),
    .select_n_i(sel_n), .serial_cmd_in_i(mosi), .serial_data_o(sdo),
    .serial_data_oe_o(sdo_oe), .protect_bits_i(prot), .status_o(status),
    .active_o(active), .core_start_o(start), .core_req_o(req),
    .core_rd_idx_i(rd_idx), .core_rd_byte_o(rd_byte), .core_rd_keep_o(keep));
  // Largest variant on the same link; each answers only its own ID command
  fsq_sequencer #(.PROG_CYCLES_P(20), .SECT_CYCLES_P(30), .BULK_CYCLES_P(90),
    .LARGEST_P(1'b1)) uut2 (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .serial_clock_i(sclk),
    .select_n_i(sel_n), .serial_cmd_in_i(mosi), .serial_data_o(sdo2),
    .serial_data_oe_o(sdo_oe2), .protect_bits_i(prot), .status_o(),
    .active_o(), .core_start_o(), .core_req_o(),
    .core_rd_idx_i(rd_idx), .core_rd_byte_o(), .core_rd_keep_o());
  fsq_host host (.data_i(sdo | sdo2), .oe_i(sdo_oe | sdo_oe2), .sclk_o(sclk),
    .sel_n_o(sel_n), .mosi_o(mosi));

////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ends on a falling edge so later samples never race the clock
  task automatic send(input int n = 0);
    host.frame(fr, n, rd, oe_seen);
    @(negedge sys_clk);
  endtask

  task automatic wen();
    fr = '{CMD_WRITE_EN};
    send();
  endtask

  // Bounded wait for the cycle, then select-high standby
  task automatic wait_idle();
    for (int i = 0; i < 100 && status[0] !== 1'b0; i++)
      @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    chk("standby", 0, active);
  endtask

  // Program random bytes, then read the whole buffer back
  task automatic prog(input logic [23:0] a, input int n);
    logic [7:0] ed[256];
    logic       ek[256];
    ek = '{default: 1'b0};
    wen();
    fr = '{CMD_PAGE_PROG, a[23:16], a[15:8], a[7:0]};
    for (int j = 0; j < n; j++) begin
      fr.push_back(8'($urandom));
      ed[8'(a[7:0] + j)] = fr[j + 4];
      ek[8'(a[7:0] + j)] = 1'b1;
    end
    exp_q.push_back(fsq_core_req_s'{OP_PROG, a[22:0]});
    send();
    wait_idle();
    for (int i = 0; i < 256; i++) begin
      rd_idx = 8'(i);
      @(negedge sys_clk);
      chk("keep", ek[i], keep);
      if (ek[i]) chk("byte", ed[i], rd_byte);
    end
  endtask

  // Pair each start with the oldest note and time the busy flag
  always @(negedge sys_clk) begin : watch
    fsq_core_req_s e;
    int n;
    if (resetn === 1'b1 && start === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected start", 0, 1);
      end else begin
        e = exp_q.pop_front();
        chk("op", e.op, req.op);
        if (e.op != OP_BULK) chk("addr", e.addr, req.addr);
        chk("latch clear", 0, status[1]);
        chk("active", 1, active);
        n = 0;
        while (status[0] === 1'b1 && n < 100) begin
          n++;
          @(negedge sys_clk);
        end
        chk("busy cycles", 1, n >= LEN[e.op] && n <= LEN[e.op] + 2);
      end
    end
  end

  // Hang guard; the full run needs well under this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    prot = 3'h0;
    rd_idx = 8'h00;
    void'($urandom(32'h22086bb5));
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("status reset", 0, status);
    // Empty select pulse also clears both link sides before the first frame
    host.restart();
    chk("restart quiet", 0, status);
    // Identification; the second silicon ID byte read is the repeat
    fr = '{CMD_SILICON_ID, 8'h00, 8'h00, 8'h00};
    send(16);
    chk("silicon id", {SILICON_ID, SILICON_ID}, rd);
    fr = '{CMD_DEVICE_ID, 8'h00, 8'h00};
    send(16);
    chk("device id", DEVICE_ID, rd);
    chk("id drive", 1, oe_seen);
    $display("test ids done");
    // Refused frames: no latch, broken boundary, protected, disabled
    fr = '{CMD_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h5c};
    send();
    chk("no latch", 0, status[0]);
    wen();
    chk("latch set", 1, status[1]);
    fr = '{CMD_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h5c};
    send(3);
    chk("off boundary", 0, status[0]);
    for (int p = 1; p < 8; p++) begin
      prot = 3'(p);
      wen();
      fr = '{CMD_SECTOR_ERASE, 8'h7f, 8'h00, 8'h00};
      send();
      fr = '{CMD_BULK_ERASE};
      send();
      chk("protected", 1, status[1]);
    end
    prot = 3'h0;
    fr = '{CMD_WRITE_DIS};
    send();
    fr = '{CMD_BULK_ERASE};
    send();
    chk("disabled", 0, status);
    $display("test refusals done");
    // Wrap at page end with top address bit set, then an overlong frame
    prog(24'h8012fe, 3);
    prog(24'h000100, 258);
    $display("test program done");
    wen();
    exp_q.push_back(fsq_core_req_s'{OP_SECT, 23'h050000});
    fr = '{CMD_SECTOR_ERASE, 8'h85, 8'h00, 8'h00};
    send();
    wait_idle();
    wen();
    exp_q.push_back(fsq_core_req_s'{OP_BULK, 23'h000000});
    fr = '{CMD_BULK_ERASE};
    send();
    // ID frame entirely inside the bulk cycle must stay silent
    fr = '{CMD_SILICON_ID, 8'h00, 8'h00, 8'h00};
    send(16);
    chk("id while busy", 0, oe_seen);
    wait_idle();
    $display("test erase done");
    chk("pending starts", 0, exp_q.size());
    finish_test();
  end
endmodule // fsq_sequencer_tb_top

`default_nettype wire
